/* design/fbmf_pkg.sv */
// Constants, register map and state type of the fieldbus message host controller
package fbmf_pkg;

  // ********************************************************
  // Exchange areas
  // ********************************************************
  localparam int unsigned INPUT_AREA_SIZE = 16;
  localparam int unsigned OUTPUT_AREA_SIZE = 8;
  localparam int unsigned MIN_AREA_SIZE = 8;
  localparam int unsigned HDR_BYTES = 4;
  localparam int unsigned IN_PAYLOAD = INPUT_AREA_SIZE - HDR_BYTES;
  localparam int unsigned OUT_PAYLOAD = OUTPUT_AREA_SIZE - HDR_BYTES;
  localparam int unsigned MAX_MSG = 256;
  localparam int unsigned BYTE_CTRL = 0;
  localparam int unsigned BYTE_STATION = 1;
  localparam int unsigned BYTE_SELECTOR = 2;
  localparam int unsigned BYTE_LENGTH = 3;
  localparam int unsigned BYTE_CMD0 = 4;
  localparam int unsigned BYTE_CMD1 = 5;
  localparam int unsigned BIT_POSTED = 0;
  localparam int unsigned BIT_CONSUMED = 1;
  localparam int unsigned BIT_RESYNC = 2;
  localparam int unsigned BIT_MORE = 3;

  // ********************************************************
  // Service selectors and management characters
  // ********************************************************
  localparam logic [7:0] SEL_ACQ = 8'h00;
  localparam logic [7:0] SEL_HOSTMODE = 8'h02;
  localparam logic [7:0] SEL_MGMT = 8'hFF;
  localparam logic [7:0] CH_FLUSH0 = 8'h5B;
  localparam logic [7:0] CH_FLUSH1 = 8'h46;
  localparam logic [7:0] CH_ACCEPT = 8'h41;
  localparam logic [7:0] CH_REJECT = 8'h43;
  localparam logic [7:0] FLUSH_LEN = 8'h02;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned RESYNC_TIME_MS = 1000;
  localparam int unsigned RESYNC_CYCLES = RESYNC_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned TMR_W = 27;

  // ********************************************************
  // Register map (byte offsets) and reset values
  // ********************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_TX_LEN = 8'h08;
  localparam logic [7:0] REG_TX_DATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RX_DATA = 8'h14;
  localparam logic [7:0] RST_STATION = 8'h00;
  localparam logic [7:0] RST_SELECTOR = 8'h00;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_TX_LOAD, ST_TX_WAIT, ST_RX_COPY, ST_RESYNC} fbmf_state_e;

endpackage : fbmf_pkg

/* design/fbmf_reg_if.sv */
// Register access carrier between the bus slave and the controller core
`timescale 1ns/10ps
interface fbmf_reg_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus (output wr, output rd, output addr, output wdata, input rdata);
  modport core (input wr, input rd, input addr, input wdata, output rdata);
endinterface : fbmf_reg_if

/* design/fbmf_ahb_slave.sv */
// AHB-Lite slave front end, zero wait states
`timescale 1ns/10ps
module fbmf_ahb_slave (
  input logic clk,
  input logic rst_n,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic hready,
  input logic [31:0] hwdata,
  output logic [31:0] hrdata,
  fbmf_reg_if.bus regs
);
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;

  // Only aligned word transfers in the low 256 bytes are taken; others read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1] && (hsize == fbmf_pkg::HSIZE_WORD) &&
                  (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  assign regs.wr = ph_valid && ph_write;
  assign regs.rd = ph_valid && !ph_write;
  assign regs.addr = ph_addr;
  assign regs.wdata = hwdata;
  assign hrdata = regs.rd ? regs.rdata : 32'h00000000;
endmodule : fbmf_ahb_slave

/* design/fbmf_hold_timer.sv */
// Down counter that times the resynchronisation hold
`timescale 1ns/10ps
module fbmf_hold_timer #(
  parameter int unsigned CYCLES = fbmf_pkg::RESYNC_CYCLES
) (
  input logic clk,
  input logic rst_n,
  input logic start,
  output logic busy,
  output logic done
);
  logic [fbmf_pkg::TMR_W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= fbmf_pkg::TMR_W'(CYCLES);
    end else if (cnt != '0) begin
      cnt <= cnt - fbmf_pkg::TMR_W'(1);
    end
  end

  assign busy = (cnt != '0);
  assign done = (cnt == fbmf_pkg::TMR_W'(1));
endmodule : fbmf_hold_timer

/* design/fbmf_host.sv */
// Fieldbus message layer host: fragments, reassembles, flushes and resyncs a slave
// Overview of operation
// - Continuation bit 3 is one on every fragment but the last.
// - Each fragment completes its own toggle handshake before the next one.
// - Reassembled data goes upward only after a fragment with continuation zero.
// - Non-final length equals area size minus 4; final at most that.
// - Total length is (fragments-1) times payload plus final length byte.
// - Byte 1 of both areas holds the device station address.
// - Selector 0 is acquisition, 2 is host mode, 255 is management.
// - Selectors 255 and 2 are reserved; others need agreement of both ends.
// - Host may request a flush on selector 255 with '[' and 'F'.
// - Host acknowledges every new event by toggling output control bit 0.
// - Host sets input and output area lengths to at least 8 bytes.
// - Host usually flushes the device queues at startup, but may skip it.
// - Resync holds output bit 2 for 1 second, then handshake bits clear.
// - Control bits 4 to 7 are always zero in both areas.
`timescale 1ns/10ps
module fbmf_host #(
  parameter int unsigned RESYNC_CYCLES = fbmf_pkg::RESYNC_CYCLES
) (
  input logic CLK,
  input logic RST_N,
  input logic HSEL,
  input logic [31:0] HADDR,
  input logic [1:0] HTRANS,
  input logic HWRITE,
  input logic [2:0] HSIZE,
  input logic HREADY,
  input logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input logic [8*fbmf_pkg::INPUT_AREA_SIZE-1:0] IN_AREA,
  output logic [8*fbmf_pkg::OUTPUT_AREA_SIZE-1:0] OUT_AREA
);

  // ********************************************************
  // Bus front end and helpers
  // ********************************************************
  fbmf_reg_if regs ();

  fbmf_ahb_slave u_ahb (
    .clk(CLK),
    .rst_n(RST_N),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hready(HREADY),
    .hwdata(HWDATA),
    .hrdata(HRDATA),
    .regs(regs.bus)
  );

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  function automatic logic reg_wr(input logic wr, input logic [7:0] a, input logic [7:0] off);
    reg_wr = wr && (a == off);
  endfunction : reg_wr

  function automatic logic [7:0] in_byte(input logic [127:0] area, input logic [3:0] idx);
    in_byte = area[{idx, 3'b000} +: 8];
  endfunction : in_byte

  fbmf_pkg::fbmf_state_e state;
  logic [7:0] out_b [fbmf_pkg::OUTPUT_AREA_SIZE];
  logic [7:0] station;
  logic [7:0] selector;
  logic [8:0] tx_len;
  logic [8:0] tx_wr;
  logic [8:0] tx_rd;
  logic [8:0] tx_rem;
  logic [7:0] tx_mem [fbmf_pkg::MAX_MSG];
  logic [7:0] rx_mem [fbmf_pkg::MAX_MSG];
  logic [8:0] rx_wr;
  logic [8:0] rx_rd;
  logic [8:0] rx_len;
  logic [4:0] rx_frag;
  logic [7:0] rx_sel;
  logic [3:0] cidx;
  logic pend_send;
  logic pend_flush;
  logic pend_resync;
  logic rx_ready;
  logic rx_overflow;
  logic flush_ok;
  logic flush_rej;
  logic dev_online;
  logic tmr_busy;
  logic tmr_done;

  logic [7:0] in_ctl;
  logic [7:0] in_sel;
  logic [7:0] in_len;
  logic [3:0] rx_cnt;
  logic [7:0] frag_len;
  logic rx_new;
  logic rx_done;
  logic tx_consumed;
  logic take_resync;
  logic take_flush;
  logic take_send;
  logic tx_clear;
  logic rx_release;

  genvar g;
  generate
    for (g = 0; g < fbmf_pkg::OUTPUT_AREA_SIZE; g++) begin : g_out
      assign OUT_AREA[8*g +: 8] = out_b[g];
    end
  endgenerate

  // ********************************************************
  // Handshake decode
  // ********************************************************
  always_comb begin
    in_ctl = in_byte(IN_AREA, 4'(fbmf_pkg::BYTE_CTRL));
    in_sel = in_byte(IN_AREA, 4'(fbmf_pkg::BYTE_SELECTOR));
    in_len = in_byte(IN_AREA, 4'(fbmf_pkg::BYTE_LENGTH));
    rx_cnt = (in_len > 8'(fbmf_pkg::IN_PAYLOAD)) ? 4'(fbmf_pkg::IN_PAYLOAD) : in_len[3:0];
    frag_len = (tx_rem > 9'(fbmf_pkg::OUT_PAYLOAD)) ? 8'(fbmf_pkg::OUT_PAYLOAD) : tx_rem[7:0];
    // Reception stalls while software still holds the previous message
    rx_new = (state == fbmf_pkg::ST_IDLE) && !rx_ready &&
             (in_ctl[fbmf_pkg::BIT_POSTED] != out_b[0][fbmf_pkg::BIT_POSTED]);
    rx_done = (state == fbmf_pkg::ST_RX_COPY) && ((rx_cnt == 4'h0) || (cidx == rx_cnt - 4'h1));
    tx_consumed = (in_ctl[fbmf_pkg::BIT_CONSUMED] == out_b[0][fbmf_pkg::BIT_CONSUMED]);
    take_resync = (state == fbmf_pkg::ST_IDLE) && !rx_new && pend_resync;
    take_flush = (state == fbmf_pkg::ST_IDLE) && !rx_new && !pend_resync && pend_flush;
    take_send = (state == fbmf_pkg::ST_IDLE) && !rx_new && !pend_resync && !pend_flush &&
                pend_send;
    tx_clear = reg_wr(regs.wr, regs.addr, fbmf_pkg::REG_CTRL) && regs.wdata[4];
    rx_release = reg_wr(regs.wr, regs.addr, fbmf_pkg::REG_CTRL) && regs.wdata[3];
  end

  fbmf_hold_timer #(
    .CYCLES(RESYNC_CYCLES)
  ) u_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .start(take_resync),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ********************************************************
  // Software registers
  // ********************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      station <= fbmf_pkg::RST_STATION;
      selector <= fbmf_pkg::RST_SELECTOR;
      tx_len <= 9'h000;
    end else begin
      if (reg_wr(regs.wr, regs.addr, fbmf_pkg::REG_CFG)) begin
        station <= regs.wdata[7:0];
        selector <= regs.wdata[15:8];
      end
      if (reg_wr(regs.wr, regs.addr, fbmf_pkg::REG_TX_LEN)) begin
        // Longer messages are clipped: the transmit buffer holds only 256 bytes
        tx_len <= (regs.wdata[15:0] > 16'(fbmf_pkg::MAX_MSG)) ? 9'(fbmf_pkg::MAX_MSG) :
                  regs.wdata[8:0];
      end
    end
  end

  // Commands: a new write wins over the take in the same cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pend_send <= 1'b0;
      pend_flush <= 1'b0;
      pend_resync <= 1'b0;
    end else begin
      if (take_send) pend_send <= 1'b0;
      if (take_flush) pend_flush <= 1'b0;
      if (take_resync) pend_resync <= 1'b0;
      if (reg_wr(regs.wr, regs.addr, fbmf_pkg::REG_CTRL)) begin
        if (regs.wdata[0]) pend_send <= 1'b1;
        if (regs.wdata[1]) pend_flush <= 1'b1;
        if (regs.wdata[2]) pend_resync <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (state == fbmf_pkg::ST_IDLE && !pend_send &&
        reg_wr(regs.wr, regs.addr, fbmf_pkg::REG_TX_DATA) && tx_wr < 9'(fbmf_pkg::MAX_MSG)) begin
      tx_mem[tx_wr[7:0]] <= regs.wdata[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_wr <= 9'h000;
    end else if (tx_clear) begin
      tx_wr <= 9'h000;
    end else if (state == fbmf_pkg::ST_IDLE && !pend_send &&
                 reg_wr(regs.wr, regs.addr, fbmf_pkg::REG_TX_DATA) &&
                 tx_wr < 9'(fbmf_pkg::MAX_MSG)) begin
      tx_wr <= tx_wr + 9'h001;
    end
  end

  always_comb begin
    if (regs.addr == fbmf_pkg::REG_CFG) begin
      regs.rdata = {16'h0000, selector, station};
    end else if (regs.addr == fbmf_pkg::REG_TX_LEN) begin
      regs.rdata = {23'h000000, tx_len};
    end else if (regs.addr == fbmf_pkg::REG_STATUS) begin
      regs.rdata = {7'h00, rx_len, rx_sel, 2'h0, rx_overflow, dev_online, flush_rej, flush_ok,
                    rx_ready, (state != fbmf_pkg::ST_IDLE) || pend_send || pend_flush ||
                    pend_resync};
    end else if (regs.addr == fbmf_pkg::REG_RX_DATA) begin
      regs.rdata = {24'h000000, rx_mem[rx_rd[7:0]]};
    end else begin
      regs.rdata = 32'h00000000;
    end
  end

  // ********************************************************
  // Link sequencer and output area
  // ********************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= fbmf_pkg::ST_IDLE;
      for (int i = 0; i < fbmf_pkg::OUTPUT_AREA_SIZE; i++) begin
        out_b[i] <= 8'h00;
      end
      cidx <= 4'h0;
      tx_rd <= 9'h000;
      tx_rem <= 9'h000;
    end else begin
      case (state)
        fbmf_pkg::ST_IDLE: begin
          cidx <= 4'h0;
          if (rx_new) begin
            state <= fbmf_pkg::ST_RX_COPY;
          end else if (take_resync) begin
            out_b[0] <= 8'h00;
            out_b[0][fbmf_pkg::BIT_RESYNC] <= 1'b1;
            state <= fbmf_pkg::ST_RESYNC;
          end else if (take_flush) begin
            out_b[fbmf_pkg::BYTE_STATION] <= station;
            out_b[fbmf_pkg::BYTE_SELECTOR] <= fbmf_pkg::SEL_MGMT;
            out_b[fbmf_pkg::BYTE_LENGTH] <= fbmf_pkg::FLUSH_LEN;
            out_b[fbmf_pkg::BYTE_CMD0] <= fbmf_pkg::CH_FLUSH0;
            out_b[fbmf_pkg::BYTE_CMD1] <= fbmf_pkg::CH_FLUSH1;
            out_b[0][fbmf_pkg::BIT_MORE] <= 1'b0;
            out_b[0][fbmf_pkg::BIT_CONSUMED] <= ~out_b[0][fbmf_pkg::BIT_CONSUMED];
            tx_rem <= 9'h000;
            state <= fbmf_pkg::ST_TX_WAIT;
          end else if (take_send && tx_len != 9'h000) begin
            tx_rd <= 9'h000;
            tx_rem <= tx_len;
            state <= fbmf_pkg::ST_TX_LOAD;
          end
        end
        fbmf_pkg::ST_TX_LOAD: begin
          // One payload byte a cycle; unused tail bytes go out as zero
          out_b[3'(cidx + 4'(fbmf_pkg::HDR_BYTES))] <=
            (8'(cidx) < frag_len) ? tx_mem[8'(tx_rd + 9'(cidx))] : 8'h00;
          cidx <= cidx + 4'h1;
          if (cidx == 4'(fbmf_pkg::OUT_PAYLOAD - 1)) begin
            out_b[fbmf_pkg::BYTE_STATION] <= station;
            out_b[fbmf_pkg::BYTE_SELECTOR] <= selector;
            out_b[fbmf_pkg::BYTE_LENGTH] <= frag_len;
            out_b[0][fbmf_pkg::BIT_MORE] <= (tx_rem > 9'(fbmf_pkg::OUT_PAYLOAD));
            out_b[0][fbmf_pkg::BIT_CONSUMED] <= ~out_b[0][fbmf_pkg::BIT_CONSUMED];
            state <= fbmf_pkg::ST_TX_WAIT;
          end
        end
        fbmf_pkg::ST_TX_WAIT: begin
          if (tx_consumed) begin
            tx_rd <= tx_rd + 9'(frag_len);
            tx_rem <= tx_rem - 9'(frag_len);
            cidx <= 4'h0;
            if (tx_rem > 9'(fbmf_pkg::OUT_PAYLOAD)) begin
              state <= fbmf_pkg::ST_TX_LOAD;
            end else begin
              state <= fbmf_pkg::ST_IDLE;
            end
          end
        end
        fbmf_pkg::ST_RX_COPY: begin
          cidx <= cidx + 4'h1;
          if (rx_done) begin
            out_b[0][fbmf_pkg::BIT_POSTED] <= ~out_b[0][fbmf_pkg::BIT_POSTED];
            state <= fbmf_pkg::ST_IDLE;
          end
        end
        fbmf_pkg::ST_RESYNC: begin
          if (tmr_done) begin
            out_b[0] <= 8'h00;
            state <= fbmf_pkg::ST_IDLE;
          end
        end
        default: state <= fbmf_pkg::ST_IDLE;
      endcase
    end
  end

  // ********************************************************
  // Reassembly and status
  // ********************************************************
  always_ff @(posedge CLK) begin
    if (state == fbmf_pkg::ST_RX_COPY && cidx < rx_cnt && rx_wr < 9'(fbmf_pkg::MAX_MSG)) begin
      rx_mem[rx_wr[7:0]] <= in_byte(IN_AREA, cidx + 4'(fbmf_pkg::HDR_BYTES));
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_wr <= 9'h000;
      rx_rd <= 9'h000;
      rx_len <= 9'h000;
      rx_frag <= 5'h00;
      rx_sel <= 8'h00;
      rx_ready <= 1'b0;
      rx_overflow <= 1'b0;
      flush_ok <= 1'b0;
      flush_rej <= 1'b0;
      dev_online <= 1'b0;
    end else begin
      if (rx_release) begin
        rx_wr <= 9'h000;
        rx_rd <= 9'h000;
        rx_frag <= 5'h00;
        rx_ready <= 1'b0;
        rx_overflow <= 1'b0;
      end
      if (reg_wr(regs.rd, regs.addr, fbmf_pkg::REG_RX_DATA) && rx_rd < rx_len) begin
        rx_rd <= rx_rd + 9'h001;
      end
      if (take_flush) begin
        flush_ok <= 1'b0;
        flush_rej <= 1'b0;
      end
      if (take_resync) dev_online <= 1'b0;
      if (state == fbmf_pkg::ST_RESYNC && in_ctl[fbmf_pkg::BIT_RESYNC]) dev_online <= 1'b1;
      if (state == fbmf_pkg::ST_RX_COPY && cidx < rx_cnt) begin
        if (rx_wr < 9'(fbmf_pkg::MAX_MSG)) begin
          rx_wr <= rx_wr + 9'h001;
        end else begin
          rx_overflow <= 1'b1;
        end
      end
      if (rx_done) begin
        if (in_ctl[fbmf_pkg::BIT_MORE]) begin
          rx_frag <= rx_frag + 5'h01;
        end else if (in_sel == fbmf_pkg::SEL_MGMT) begin
          // Management answers are consumed here, never handed to software
          flush_ok <= (in_byte(IN_AREA, 4'(fbmf_pkg::BYTE_CMD0)) == fbmf_pkg::CH_ACCEPT);
          flush_rej <= (in_byte(IN_AREA, 4'(fbmf_pkg::BYTE_CMD0)) != fbmf_pkg::CH_ACCEPT);
          rx_wr <= 9'h000;
          rx_frag <= 5'h00;
        end else begin
          rx_ready <= 1'b1;
          rx_sel <= in_sel;
          rx_len <= 9'(rx_frag * 9'(fbmf_pkg::IN_PAYLOAD)) + 9'(rx_cnt);
        end
      end
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  property p_ctl_high_zero;
    @(posedge CLK) disable iff (!RST_N) out_b[0][7:4] == 4'h0;
  endproperty
  a_ctl_high_zero: assert property (p_ctl_high_zero) else $error("control high bits set");

  property p_station;
    @(posedge CLK) disable iff (!RST_N)
      (state == fbmf_pkg::ST_TX_WAIT) |-> out_b[fbmf_pkg::BYTE_STATION] == station;
  endproperty
  a_station: assert property (p_station) else $error("station byte wrong");

  property p_more_len;
    @(posedge CLK) disable iff (!RST_N)
      (state == fbmf_pkg::ST_TX_WAIT && out_b[0][fbmf_pkg::BIT_MORE]) |->
        out_b[fbmf_pkg::BYTE_LENGTH] == 8'(fbmf_pkg::OUT_PAYLOAD);
  endproperty
  a_more_len: assert property (p_more_len) else $error("non-final length wrong");

  property p_len_max;
    @(posedge CLK) disable iff (!RST_N)
      out_b[fbmf_pkg::BYTE_LENGTH] <= 8'(fbmf_pkg::OUT_PAYLOAD);
  endproperty
  a_len_max: assert property (p_len_max) else $error("length exceeds payload");

  property p_one_toggle;
    @(posedge CLK) disable iff (!RST_N)
      (state == fbmf_pkg::ST_TX_WAIT && !tx_consumed) |=>
        $stable(out_b[0][fbmf_pkg::BIT_CONSUMED]) && $stable(out_b[fbmf_pkg::BYTE_LENGTH]);
  endproperty
  a_one_toggle: assert property (p_one_toggle) else $error("fragment changed early");

  property p_ack;
    @(posedge CLK) disable iff (!RST_N)
      rx_done |=> out_b[0][fbmf_pkg::BIT_POSTED] != $past(out_b[0][fbmf_pkg::BIT_POSTED]);
  endproperty
  a_ack: assert property (p_ack) else $error("event not acknowledged");

  property p_deliver;
    @(posedge CLK) disable iff (!RST_N)
      $rose(rx_ready) |-> !$past(in_ctl[fbmf_pkg::BIT_MORE]) && $past(rx_done);
  endproperty
  a_deliver: assert property (p_deliver) else $error("delivered before last fragment");

  property p_total_len;
    @(posedge CLK) disable iff (!RST_N)
      ($rose(rx_ready) && !rx_overflow) |-> rx_len == rx_wr;
  endproperty
  a_total_len: assert property (p_total_len) else $error("reassembled length wrong");

  property p_flush_req;
    @(posedge CLK) disable iff (!RST_N)
      take_flush |=> out_b[fbmf_pkg::BYTE_SELECTOR] == fbmf_pkg::SEL_MGMT &&
        out_b[fbmf_pkg::BYTE_CMD0] == fbmf_pkg::CH_FLUSH0 &&
        out_b[fbmf_pkg::BYTE_CMD1] == fbmf_pkg::CH_FLUSH1;
  endproperty
  a_flush_req: assert property (p_flush_req) else $error("flush request malformed");

  property p_resync_hold;
    @(posedge CLK) disable iff (!RST_N)
      take_resync |=> (out_b[0][fbmf_pkg::BIT_RESYNC] && tmr_busy) [*8];
  endproperty
  a_resync_hold: assert property (p_resync_hold) else $error("resync bit dropped");

  property p_rx_cap;
    @(posedge CLK) disable iff (!RST_N) rx_wr <= 9'(fbmf_pkg::MAX_MSG);
  endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("reassembly beyond limit");

endmodule : fbmf_host

/* sim/fbmf_dev.sv */
// Behavioural slave device facing the message layer host
`timescale 1ns/10ps
module fbmf_dev #(
  parameter logic [7:0] STN = 8'h03
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [63:0] OUT_AREA,
  output logic [127:0] IN_AREA
);
  logic [7:0] ev_q[$];
  logic [7:0] rx_q[$];
  int bad = 0;
  // Set by the bench so that the next flush request is refused
  logic rej = 1'b0;
  // Random stalls on consumption, so a host that skips the handshake loses data
  always @(posedge CLK) begin
    if (!RST_N) IN_AREA <= '0;
    else if (OUT_AREA[2]) IN_AREA[7:0] <= 8'h04;
    else if (IN_AREA[2]) IN_AREA[7:0] <= 8'h00;
    else if (OUT_AREA[1] != IN_AREA[1] && $urandom_range(2) == 0) begin
      if (OUT_AREA[7:4] != 0 || OUT_AREA[15:8] != STN) bad++;
      if (OUT_AREA[3] && OUT_AREA[31:24] != 4 || OUT_AREA[31:24] > 4) bad++;
      if (OUT_AREA[23:16] == 8'hFF) begin
        if (OUT_AREA[47:32] == 16'h465B && !rej) ev_q.delete();
        IN_AREA[127:8] <= '0;
        IN_AREA[39:32] <= (OUT_AREA[47:32] == 16'h465B && !rej) ? 8'h41 : 8'h43;
        IN_AREA[31:8] <= {8'h01, 8'hFF, STN};
        IN_AREA[3] <= 1'b0;
        IN_AREA[0] <= !IN_AREA[0];
      end else
        for (int k = 0; k < OUT_AREA[31:24] && k < 4; k++) rx_q.push_back(OUT_AREA[32+8*k+:8]);
      IN_AREA[1] <= !IN_AREA[1];
    end else if (IN_AREA[0] == OUT_AREA[0] && ev_q.size() > 0) begin
      IN_AREA[127:8] <= '0;
      IN_AREA[31:8] <= {8'(ev_q.size() > 12 ? 12 : ev_q.size()), 8'h00, STN};
      IN_AREA[3] <= ev_q.size() > 12;
      for (int k = 0; k < 12 && ev_q.size() > 0; k++)
        IN_AREA[32+8*k+:8] <= ev_q.pop_front();
      IN_AREA[0] <= !IN_AREA[0];
    end
  end
endmodule : fbmf_dev

/* sim/tb.sv */
// Self-checking bench for the fieldbus message layer host
`timescale 1ns/10ps
module tb;
  logic CLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0, HREADYOUT, HRESP;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA;
  logic [1:0] HTRANS = '0;
  logic [2:0] HSIZE = fbmf_pkg::HSIZE_WORD;
  logic [127:0] IN_AREA;
  logic [63:0] OUT_AREA;
  int err_total = 0, num_checks = 0;
  int lens[2] = '{6, 300};
  fbmf_host #(.RESYNC_CYCLES(20)) dut_u (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADYOUT),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .IN_AREA(IN_AREA), .OUT_AREA(OUT_AREA));
  fbmf_dev dev_u (.CLK(CLK), .RST_N(RST_N), .OUT_AREA(OUT_AREA), .IN_AREA(IN_AREA));
  initial forever #4 CLK = ~CLK;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge CLK);
    HSEL <= 1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask : ahb
  task automatic wst(input int b, input logic v, output logic [31:0] r);
    for (int n = 0; n < 1000; n++) begin
      ahb(0, fbmf_pkg::REG_STATUS, 0, r);
      if (r[b] === v) break;
    end
    chk("status", v, r[b]);
  endtask : wst
  task automatic complete_run;
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (40000) @(posedge CLK);
    err_total++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    logic [7:0] mq[$];
    int n;
    void'($urandom(32'ha410b137));
    repeat (8) @(posedge CLK);
    RST_N <= 1;
    ahb(1, fbmf_pkg::REG_CFG, 32'h1003, r);
    ahb(0, fbmf_pkg::REG_CFG, 0, r);
    chk("cfg", 32'h1003, r);
    ahb(0, 8'h40, 0, r);
    chk("unmapped", 0, r);
    foreach (lens[i]) begin
      mq.delete();
      dev_u.rx_q.delete();
      ahb(1, fbmf_pkg::REG_CTRL, 32'h10, r);
      ahb(1, fbmf_pkg::REG_TX_LEN, lens[i], r);
      for (int k = 0; k < lens[i]; k++) begin
        n = $urandom_range(255);
        if (k < 256) mq.push_back(8'(n));
        ahb(1, fbmf_pkg::REG_TX_DATA, n, r);
      end
      ahb(1, fbmf_pkg::REG_CTRL, 1, r);
      wst(0, 0, r);
      chk("rx count", mq.size(), dev_u.rx_q.size());
      chk("frame faults", 0, dev_u.bad);
      foreach (mq[k]) chk("rx byte", mq[k], dev_u.rx_q[k]);
    end
    mq.delete();
    repeat (17) begin
      n = $urandom_range(255);
      mq.push_back(8'(n));
      dev_u.ev_q.push_back(8'(n));
    end
    wst(1, 1, r);
    chk("event len", 17, r[24:16]);
    chk("event sel", fbmf_pkg::SEL_ACQ, r[15:8]);
    foreach (mq[k]) begin
      ahb(0, fbmf_pkg::REG_RX_DATA, 0, r);
      chk("event byte", mq[k], r[7:0]);
    end
    ahb(1, fbmf_pkg::REG_CTRL, 32'h8, r);
    ahb(1, fbmf_pkg::REG_CTRL, 32'h2, r);
    wst(2, 1, r);
    chk("flush rej", 0, r[3]);
    dev_u.rej = 1'b1;
    ahb(1, fbmf_pkg::REG_CTRL, 32'h2, r);
    wst(3, 1, r);
    chk("flush ok", 0, r[2]);
    ahb(1, fbmf_pkg::REG_CTRL, 32'h4, r);
    wst(0, 0, r);
    chk("online", 1, r[4]);
    chk("ctrl byte", 0, OUT_AREA[7:0]);
    complete_run();
  end
endmodule : tb
